/* inc/ebi_pkg.sv */
// Purpose: Shared constants for the external bus interface
// Assumes: 50 MHz ref_clk, classic Wishbone register port
// Notes: Register offsets are byte addresses of 32-bit words
package ebi_pkg;
    localparam int EBI_ADDR_W = 20;
    localparam int EBI_DATA_W = 16;
    localparam int EBI_AREAS = 4;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] EBI_REG_CTRL = 8'h00;
    localparam logic [7:0] EBI_REG_ADDR = 8'h04;
    localparam logic [7:0] EBI_REG_DATA = 8'h08;
    localparam logic [7:0] EBI_REG_STAT = 8'h0C;
    // CTRL fields
    localparam int EBI_CTRL_GO = 0;
    localparam int EBI_CTRL_WRITE = 1;
    localparam int EBI_CTRL_STROBE = 2;
    localparam int EBI_CTRL_MUX = 3;
    localparam int EBI_CTRL_HOLD = 4;
    localparam int EBI_CTRL_AREA = 8;
    // STAT fields
    localparam int EBI_STAT_BUSY = 0;
    localparam int EBI_STAT_WIDE8 = 1;
    localparam int EBI_STAT_MPMODE = 2;
    localparam int EBI_STAT_HOLD = 3;
    localparam logic [31:0] EBI_UNMAPPED = 32'h0000_0000;
    // Bus clock divider: half period in ref_clk cycles, less one
    localparam logic [1:0] EBI_BCLK_HALF = 2'h1;
    typedef enum logic [2:0] {
        EBI_IDLE = 3'b000,
        EBI_ADDR = 3'b001,
        EBI_STRB = 3'b011,
        EBI_WAIT = 3'b010,
        EBI_DONE = 3'b110
    } ebi_state_type;
endpackage : ebi_pkg

/* hdl/ebi_top.sv */
// Purpose: External bus interface master driven from Wishbone registers
// Assumes: Straps and ready come from pins; one access at a time
// Notes: One bus cycle is address phase, strobe phase, waits, done
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - Width strap low gives 16-bit data bus, high gives 8-bit bus.
// - Separate bus: low byte on D0-D7, high byte on D8-D15 when 16-bit.
// - Twenty address lines A0-A19 driven for external accesses.
// - 8-bit multiplexed: low lines carry A0-A7 then data.
// - 16-bit multiplexed: low lines carry A1-A8 then data.
// - Four active-low area selects name the targeted area.
// - Software picks split write strobes or write plus high-byte enable.
// - Split strobes, 16-bit: low-byte strobe pulses low for even writes.
// - Split strobes, 16-bit: high-byte strobe pulses low for odd writes.
// - Read strobe low while reading the external area.
// - Single-strobe mode: high-byte enable low for odd addresses.
// - Address latch strobe lets outside logic capture the address.
// - Hold acknowledge stays low while the bus is held.
// - Ready low stretches the cycle with wait states.
// - Bus clock is driven out on its own pin.
module ebi_top
    import ebi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic bus_width_pin,
    input wire logic processor_mode_pin,
    input wire logic ready_n,
    output logic [EBI_ADDR_W-1:0] ext_addr,
    input wire logic [EBI_DATA_W-1:0] ext_data_i,
    output logic [EBI_DATA_W-1:0] ext_data_o,
    output logic [EBI_DATA_W-1:0] ext_data_oe,
    output logic [EBI_AREAS-1:0] external_area_select_n,
    output logic store_strobe_low_byte,
    output logic store_strobe_high_byte,
    output logic high_byte_enable_n,
    output logic read_strobe_n,
    output logic addr_latch,
    output logic hold_acknowledge_n,
    output logic bus_clk
);
    // ---------------------------------------------------------------
    // Reset and pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_l;
    logic [2:0] pin_s1, pin_s2;
    logic wide8, mp_mode, rdy_n_s, strap_done;
    logic [1:0] strap_fill;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_l = rst_sync[1];
    always_ff @(posedge ref_clk or negedge rst_l) begin
        if (!rst_l) begin
            pin_s1 <= 3'b111;
            pin_s2 <= 3'b111;
        end else begin
            pin_s1 <= {bus_width_pin, processor_mode_pin, ready_n};
            pin_s2 <= pin_s1;
        end
    end
    assign rdy_n_s = pin_s2[0];
    // Straps caught once after release; later strap motion is ignored
    // Wait until both stages hold pin levels, not their reset ones
    always_ff @(posedge ref_clk or negedge rst_l) begin
        if (!rst_l) begin
            strap_fill <= 2'b00;
            strap_done <= 1'b0;
            wide8 <= 1'b0;
            mp_mode <= 1'b0;
        end else begin
            strap_fill <= {strap_fill[0], 1'b1};
            if (strap_fill[1] && !strap_done) begin
                strap_done <= 1'b1;
                wide8 <= pin_s2[2];
                mp_mode <= pin_s2[1];
            end
        end
    end
    // ---------------------------------------------------------------
    // Registers and Wishbone slave
    // ---------------------------------------------------------------
    logic [15:0] ctrl, next_ctrl;
    logic [EBI_ADDR_W-1:0] acc_addr, next_acc_addr;
    logic [15:0] acc_data, next_acc_data;
    logic [31:0] next_wb_dat_o;
    logic next_wb_ack_o;
    logic busy, start;
    logic wb_hit;
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : merge
    ebi_state_type state, next_state;
    logic done_pulse;
    logic [31:0] m;
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign busy = (state != EBI_IDLE);
    always_comb begin
        m = 32'h0000_0000;
        next_ctrl = ctrl;
        next_acc_addr = acc_addr;
        next_acc_data = acc_data;
        next_wb_dat_o = wb_dat_o;
        next_wb_ack_o = wb_hit;
        start = 1'b0;
        if (done_pulse && !ctrl[EBI_CTRL_WRITE]) begin
            next_acc_data = mux_read_data();
        end
        if (wb_hit) begin
            next_wb_dat_o = EBI_UNMAPPED;
            case (wb_adr_i)
                EBI_REG_CTRL: begin
                    next_wb_dat_o = {16'h0000, ctrl};
                    if (wb_we_i) begin
                        m = merge({16'h0000, ctrl}, wb_dat_i, wb_sel_i);
                        next_ctrl = m[15:0];
                        // Go is accepted only when idle, in microprocessor mode and with the hold bit clear
                        start = m[EBI_CTRL_GO] && !busy && mp_mode && !m[EBI_CTRL_HOLD];
                        next_ctrl[EBI_CTRL_GO] = 1'b0;
                    end
                end
                EBI_REG_ADDR: begin
                    next_wb_dat_o = {12'h000, acc_addr};
                    if (wb_we_i && !busy) begin
                        m = merge({12'h000, acc_addr}, wb_dat_i, wb_sel_i);
                        next_acc_addr = m[EBI_ADDR_W-1:0];
                    end
                end
                EBI_REG_DATA: begin
                    next_wb_dat_o = {16'h0000, acc_data};
                    if (wb_we_i && !busy) begin
                        m = merge({16'h0000, acc_data}, wb_dat_i, wb_sel_i);
                        next_acc_data = m[15:0];
                    end
                end
                EBI_REG_STAT: begin
                    next_wb_dat_o = {28'h0000_000, !hold_acknowledge_n, mp_mode, wide8, busy};
                end
                default: begin
                    next_wb_dat_o = EBI_UNMAPPED;
                end
            endcase
        end
    end
    always_ff @(posedge ref_clk or negedge rst_l) begin
        if (!rst_l) begin
            ctrl <= 16'h0000;
            acc_addr <= 20'h0_0000;
            acc_data <= 16'h0000;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            acc_addr <= next_acc_addr;
            acc_data <= next_acc_data;
            wb_dat_o <= next_wb_dat_o;
            wb_ack_o <= next_wb_ack_o;
        end
    end
    // ---------------------------------------------------------------
    // Bus clock and cycle sequencer
    // ---------------------------------------------------------------
    logic [1:0] bclk_cnt, next_bclk_cnt;
    logic next_bus_clk, tick;
    assign tick = (bclk_cnt == EBI_BCLK_HALF) && bus_clk;
    always_comb begin
        next_bclk_cnt = bclk_cnt + 2'h1;
        next_bus_clk = bus_clk;
        if (bclk_cnt == EBI_BCLK_HALF) begin
            next_bclk_cnt = 2'h0;
            next_bus_clk = !bus_clk;
        end
    end
    logic odd, mux, split;
    assign odd = acc_addr[0];
    assign mux = ctrl[EBI_CTRL_MUX];
    assign split = ctrl[EBI_CTRL_STROBE];
    function automatic logic [15:0] mux_read_data();
        // Byte lane of an odd access on a separate 16-bit bus is the high lane
        if (wide8 || mux) return {8'h00, ext_data_i[7:0]};
        return odd ? {8'h00, ext_data_i[15:8]} : ext_data_i;
    endfunction : mux_read_data
    logic [EBI_DATA_W-1:0] next_ext_data_o, next_ext_data_oe;
    logic [EBI_ADDR_W-1:0] next_ext_addr;
    logic [EBI_AREAS-1:0] next_sel_n;
    logic next_wrl, next_wrh, next_bhe_n, next_rd_n, next_ale, next_hold_acknowledge_n_n, next_done;
    always_comb begin
        next_state = state;
        next_ext_addr = ext_addr;
        next_ext_data_o = ext_data_o;
        next_ext_data_oe = 16'h0000;
        next_sel_n = 4'hF;
        next_wrl = 1'b1;
        next_wrh = 1'b1;
        next_bhe_n = 1'b1;
        next_rd_n = 1'b1;
        next_ale = 1'b0;
        next_done = 1'b0;
        next_hold_acknowledge_n_n = !(ctrl[EBI_CTRL_HOLD] && !busy);
        case (state)
            EBI_IDLE: begin
                if (start) next_state = EBI_ADDR;
            end
            EBI_ADDR: begin
                next_sel_n = ~(4'h1 << ctrl[EBI_CTRL_AREA +: 2]);
                next_ext_addr = acc_addr;
                next_ale = 1'b1;
                next_bhe_n = !(odd && !split);
                if (mux) begin
                    next_ext_data_oe = 16'h00FF;
                    next_ext_data_o = wide8 ? {8'h00, acc_addr[7:0]}
                                            : {8'h00, acc_addr[8:1]};
                end
                if (tick) next_state = EBI_STRB;
            end
            EBI_STRB, EBI_WAIT: begin
                next_sel_n = ~(4'h1 << ctrl[EBI_CTRL_AREA +: 2]);
                next_bhe_n = !(odd && !split);
                if (ctrl[EBI_CTRL_WRITE]) begin
                    if (split && !wide8) begin
                        next_wrl = odd;
                        next_wrh = !odd;
                    end else begin
                        next_wrl = 1'b0;
                    end
                    if (wide8 || mux) begin
                        next_ext_data_oe = 16'h00FF;
                        next_ext_data_o = {8'h00, acc_data[7:0]};
                    end else begin
                        next_ext_data_oe = odd ? 16'hFF00 : 16'hFFFF;
                        next_ext_data_o = odd ? {acc_data[7:0], 8'h00} : acc_data;
                    end
                end else begin
                    next_rd_n = 1'b0;
                end
                if (tick) next_state = rdy_n_s ? EBI_DONE : EBI_WAIT;
                // Done flag stands while the read strobe is still low
                if (tick && rdy_n_s) next_done = 1'b1;
            end
            EBI_DONE: begin
                next_state = EBI_IDLE;
            end
            default: next_state = EBI_IDLE;
        endcase
    end
    always_ff @(posedge ref_clk or negedge rst_l) begin
        if (!rst_l) begin
            state <= EBI_IDLE;
            bclk_cnt <= 2'h0;
            bus_clk <= 1'b0;
            ext_addr <= 20'h0_0000;
            ext_data_o <= 16'h0000;
            ext_data_oe <= 16'h0000;
            external_area_select_n <= 4'hF;
            store_strobe_low_byte <= 1'b1;
            store_strobe_high_byte <= 1'b1;
            high_byte_enable_n <= 1'b1;
            read_strobe_n <= 1'b1;
            addr_latch <= 1'b0;
            hold_acknowledge_n <= 1'b1;
            done_pulse <= 1'b0;
        end else begin
            state <= next_state;
            bclk_cnt <= next_bclk_cnt;
            bus_clk <= next_bus_clk;
            ext_addr <= next_ext_addr;
            ext_data_o <= next_ext_data_o;
            ext_data_oe <= next_ext_data_oe;
            external_area_select_n <= next_sel_n;
            store_strobe_low_byte <= next_wrl;
            store_strobe_high_byte <= next_wrh;
            high_byte_enable_n <= next_bhe_n;
            read_strobe_n <= next_rd_n;
            addr_latch <= next_ale;
            hold_acknowledge_n <= next_hold_acknowledge_n_n;
            done_pulse <= next_done;
        end
    end
    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_l);
    wait_hold_a: assert property ((state inside {EBI_STRB, EBI_WAIT} && tick && !rdy_n_s)
        |=> state == EBI_WAIT)
        else $error("cycle left wait while ready low");
    even_wr_a: assert property ((state == EBI_STRB && ctrl[EBI_CTRL_WRITE] && split && !wide8
        && !odd) |=> !store_strobe_low_byte && store_strobe_high_byte)
        else $error("even split write strobe wrong");
    odd_wr_a: assert property ((state == EBI_STRB && ctrl[EBI_CTRL_WRITE] && split && !wide8
        && odd) |=> store_strobe_low_byte && !store_strobe_high_byte)
        else $error("odd split write strobe wrong");
    read_strb_a: assert property ((state == EBI_STRB && !ctrl[EBI_CTRL_WRITE]) |=> !read_strobe_n)
        else $error("read strobe missing");
    bhe_odd_a: assert property ((state == EBI_STRB && !split && odd) |=> !high_byte_enable_n)
        else $error("high byte enable missing");
    single_wr_a: assert property ((state == EBI_STRB && ctrl[EBI_CTRL_WRITE] && !split)
        |=> !store_strobe_low_byte)
        else $error("common write strobe missing");
    ale_addr_a: assert property ((state == EBI_ADDR) |=> addr_latch && ext_addr == $past(acc_addr))
        else $error("address phase wrong");
    area_one_a: assert property ((state == EBI_STRB) |=> $countones(~external_area_select_n) == 1)
        else $error("area select not one-hot");
    hold_ack_a: assert property ((ctrl[EBI_CTRL_HOLD] && !busy) |=> !hold_acknowledge_n)
        else $error("hold acknowledge missing");
    mux_adr_a: assert property ((state == EBI_ADDR && mux && !wide8) |=>
        ext_data_o[7:0] == $past(acc_addr[8:1]) && ext_data_oe == 16'h00FF)
        else $error("muxed address wrong");
    bclk_a: assert property (bclk_cnt == EBI_BCLK_HALF |=> bus_clk != $past(bus_clk))
        else $error("bus clock stalled");
    wr_cov: cover property (state == EBI_STRB && ctrl[EBI_CTRL_WRITE]);
    rd_cov: cover property (state == EBI_DONE && !ctrl[EBI_CTRL_WRITE]);
    wait_cov: cover property (state == EBI_WAIT);
    hold_cov: cover property (!hold_acknowledge_n);
endmodule : ebi_top

/* bench/ebi_mem_model.sv */
// Purpose: Behavioural memory on the far side of the external bus
// Assumes: Same ref_clk as the bus master; no pull on the data lines
// Notes: Counts strobe pulses and keeps what it saw for the bench
`timescale 1ns/100ps
module ebi_mem_model
    import ebi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic clr,
    input wire logic [3:0] wait_cycles,
    input wire logic [EBI_ADDR_W-1:0] ext_addr,
    input wire logic [EBI_DATA_W-1:0] ext_data_o,
    input wire logic [EBI_DATA_W-1:0] ext_data_oe,
    input wire logic [EBI_AREAS-1:0] external_area_select_n,
    input wire logic store_strobe_low_byte,
    input wire logic store_strobe_high_byte,
    input wire logic high_byte_enable_n,
    input wire logic read_strobe_n,
    input wire logic addr_latch,
    output logic [EBI_DATA_W-1:0] ext_data_i,
    output logic ready_n
);
    // ---------------------------------------------------------------
    // Observation state
    // ---------------------------------------------------------------
    logic [15:0] last_q = 16'h0000;
    logic [7:0] stb_len = 8'h00;
    logic prev_wrl = 1'b1;
    logic prev_wrh = 1'b1;
    logic prev_rd = 1'b1;
    logic act;
    int wrl_cnt, wrh_cnt, rd_cnt, rd_len;
    logic bhe_wr;
    logic [15:0] wr_data, wr_oe;
    logic [7:0] ale_lo;
    logic [3:0] sel_seen;
    logic [19:0] seen_addr;
    // Hold request pin does not exist here: the board ties it high
    assign act = !store_strobe_low_byte || !store_strobe_high_byte || !read_strobe_n;
    // Stretch each strobe by wait_cycles with ready low
    assign ready_n = !(act && stb_len < {4'h0, wait_cycles});
    // Undriven lines toggle so a stale sample never looks right
    assign ext_data_i = !read_strobe_n ? {4'hA, ext_addr[3:0], 4'h5, ext_addr[3:0]} : ~last_q;
    always @(posedge ref_clk) begin
        last_q <= ext_data_i;
        prev_wrl <= store_strobe_low_byte;
        prev_wrh <= store_strobe_high_byte;
        prev_rd <= read_strobe_n;
        stb_len <= act ? stb_len + 8'h01 : 8'h00;
        if (clr) begin
            wrl_cnt <= 0;
            wrh_cnt <= 0;
            rd_cnt <= 0;
            rd_len <= 0;
        end else begin
            if (prev_wrl && !store_strobe_low_byte) wrl_cnt <= wrl_cnt + 1;
            if (prev_wrh && !store_strobe_high_byte) wrh_cnt <= wrh_cnt + 1;
            if (prev_rd && !read_strobe_n) rd_cnt <= rd_cnt + 1;
            if (!read_strobe_n) rd_len <= rd_len + 1;
        end
        if (!store_strobe_low_byte || !store_strobe_high_byte) begin
            wr_data <= ext_data_o;
            wr_oe <= ext_data_oe;
            bhe_wr <= high_byte_enable_n;
        end
        if (act) begin
            sel_seen <= external_area_select_n;
            seen_addr <= ext_addr;
        end
        if (addr_latch) ale_lo <= ext_data_o[7:0];
    end
endmodule : ebi_mem_model

/* bench/external_bus_interface_test.sv */
// Purpose: Self-checking bench for the external bus interface
// Assumes: Straps change only while reset is held
// Notes: Expected values come from the bus rules, not the design
`timescale 1ns/100ps
module external_bus_interface_test;
    import ebi_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [3:0] wb_sel = 4'h0, wait_cycles = 4'h0;
    logic bus_width_pin = 1'b0, processor_mode_pin = 1'b1, clr = 1'b1;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, ready_n, store_strobe_low_byte, store_strobe_high_byte;
    logic high_byte_enable_n, read_strobe_n, addr_latch, hold_acknowledge_n, bus_clk;
    logic [19:0] ext_addr;
    logic [15:0] ext_data_i, ext_data_o, ext_data_oe;
    logic [3:0] external_area_select_n;
    int errors = 0, tests_run = 0;
    localparam logic [31:0] WR = 32'h0000_0002, SPLIT = 32'h0000_0004, MUX = 32'h0000_0008;
    always #10 ref_clk = ~ref_clk;
    ebi_top u_ebi_top (.ref_clk(ref_clk), .rst_n(rst_n), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_ack_o(wb_ack_o), .bus_width_pin(bus_width_pin),
        .processor_mode_pin(processor_mode_pin), .ready_n(ready_n), .ext_addr(ext_addr),
        .ext_data_i(ext_data_i), .ext_data_o(ext_data_o), .ext_data_oe(ext_data_oe),
        .external_area_select_n(external_area_select_n),
        .store_strobe_low_byte(store_strobe_low_byte),
        .store_strobe_high_byte(store_strobe_high_byte), .high_byte_enable_n(high_byte_enable_n),
        .read_strobe_n(read_strobe_n), .addr_latch(addr_latch),
        .hold_acknowledge_n(hold_acknowledge_n), .bus_clk(bus_clk));
    ebi_mem_model u_ebi_mem_model (.ref_clk(ref_clk), .clr(clr), .wait_cycles(wait_cycles),
        .ext_addr(ext_addr), .ext_data_o(ext_data_o), .ext_data_oe(ext_data_oe),
        .external_area_select_n(external_area_select_n),
        .store_strobe_low_byte(store_strobe_low_byte),
        .store_strobe_high_byte(store_strobe_high_byte), .high_byte_enable_n(high_byte_enable_n),
        .read_strobe_n(read_strobe_n), .addr_latch(addr_latch), .ext_data_i(ext_data_i),
        .ready_n(ready_n));
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task finish_test;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task do_reset(input logic width, input logic mode);
        rst_n <= 1'b0;
        bus_width_pin <= width; // Straps only move under reset
        processor_mode_pin <= mode;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask : do_reset
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge ref_clk);
        wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dat <= d; wb_sel <= 4'hF;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o;
        if (n >= 50) errors++;
        wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
    endtask : wb
    // Loads address and data, starts the cycle, polls until not busy
    task ext_op(input logic [19:0] a, input logic [15:0] d, input logic [31:0] ctrl);
        int n;
        clr <= 1'b1;
        wb(1'b1, EBI_REG_ADDR, {12'h000, a}, q);
        clr <= 1'b0;
        wb(1'b1, EBI_REG_DATA, {16'h0000, d}, q);
        wb(1'b1, EBI_REG_CTRL, ctrl | 32'h0000_0001, q);
        n = 0;
        do begin
            wb(1'b0, EBI_REG_STAT, 32'h0000_0000, q);
            n++;
        end while (q[EBI_STAT_BUSY] !== 1'b0 && n < 100);
        if (n >= 100) errors++;
    endtask : ext_op
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task sc_bus_clock;
        int n;
        logic p;
        n = 0;
        p = bus_clk;
        repeat (16) begin
            @(posedge ref_clk);
            if (bus_clk === 1'b1 && p === 1'b0) n++;
            p = bus_clk;
        end
        check(n, 4);
        wb(1'b0, 8'h10, 32'h0000_0000, q);
        check(q, EBI_UNMAPPED);
    endtask : sc_bus_clock
    task sc_split16;
        ext_op(20'h1_2344, 16'hBEEF, WR | SPLIT | 32'h0000_0200);
        check(u_ebi_mem_model.wrl_cnt, 1);
        check(u_ebi_mem_model.wrh_cnt, 0);
        check(u_ebi_mem_model.wr_data, 16'hBEEF);
        check(u_ebi_mem_model.wr_oe, 16'hFFFF);
        check(u_ebi_mem_model.sel_seen, 4'b1011);
        check(u_ebi_mem_model.seen_addr, 20'h1_2344);
        ext_op(20'h0_0051, 16'h00A5, WR | SPLIT);
        check(u_ebi_mem_model.wrh_cnt, 1);
        check(u_ebi_mem_model.wrl_cnt, 0);
        check(u_ebi_mem_model.wr_data[15:8], 8'hA5);
    endtask : sc_split16
    task sc_single;
        for (int i = 0; i < 2; i++) begin
            ext_op(20'h0_0032 + 20'(i), 16'h5A5A, WR);
            check(u_ebi_mem_model.wrl_cnt, 1);
            check(u_ebi_mem_model.bhe_wr, 1'(i == 0));
        end
    endtask : sc_single
    task sc_read_slow;
        wait_cycles <= 4'h6;
        ext_op(20'h0_0046, 16'h0000, 32'h0000_0000);
        check(u_ebi_mem_model.rd_cnt, 1);
        check(u_ebi_mem_model.rd_len > 6, 1);
        wb(1'b0, EBI_REG_DATA, 32'h0000_0000, q);
        check(q[15:0], 16'hA656);
        wait_cycles <= 4'h0;
    endtask : sc_read_slow
    task sc_hold;
        wb(1'b1, EBI_REG_CTRL, 32'h0000_0010, q);
        repeat (8) @(posedge ref_clk);
        check(hold_acknowledge_n, 1'b0);
        wb(1'b0, EBI_REG_STAT, 32'h0000_0000, q);
        check(q[EBI_STAT_HOLD], 1'b1);
        wb(1'b1, EBI_REG_CTRL, 32'h0000_0000, q);
        repeat (8) @(posedge ref_clk);
        check(hold_acknowledge_n, 1'b1);
    endtask : sc_hold
    initial begin
        #200_000;
        errors++;
        finish_test();
    end
    initial begin
        do_reset(1'b0, 1'b1);
        sc_bus_clock();
        sc_split16();
        sc_single();
        sc_read_slow();
        ext_op(20'h0_0154, 16'h1234, WR | MUX);
        check(u_ebi_mem_model.ale_lo, 8'hAA);
        sc_hold();
        // Byte-wide bus: single strobe only
        do_reset(1'b1, 1'b1);
        wb(1'b0, EBI_REG_STAT, 32'h0000_0000, q);
        check(q[EBI_STAT_WIDE8], 1'b1);
        check(q[EBI_STAT_MPMODE], 1'b1);
        ext_op(20'h0_0154, 16'h00C3, WR | MUX);
        check(u_ebi_mem_model.ale_lo, 8'h54);
        check(u_ebi_mem_model.wr_data[7:0], 8'hC3);
        do_reset(1'b0, 1'b0);
        ext_op(20'h0_0010, 16'h0001, WR);
        check(u_ebi_mem_model.wrl_cnt, 0);
        check(q[EBI_STAT_MPMODE], 1'b0);
        finish_test();
    end
endmodule : external_bus_interface_test
